/* File: aks_map.vh */
// Purpose: Register offsets, field positions, codes and reset values of the key store.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes: Definitions only.
`ifndef AKS_MAP_VH
`define AKS_MAP_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define AKS_ADR_CTRL 8'h00
`define AKS_ADR_KEY 8'h04
`define AKS_ADR_CRC 8'h08
`define AKS_ADR_STAT 8'h0C
`define AKS_ADR_KSEL 8'h10
`define AKS_ADR_HELP 8'h14
`define AKS_ADR_UPD0 8'h20
`define AKS_ADR_UPD7 8'h3C

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define AKS_CTRL_TGT_LSB 0
`define AKS_CTRL_TGT_MSB 1
`define AKS_CTRL_OPEN 2
`define AKS_CTRL_BLACK 3

// Load targets
`define AKS_TGT_BATT 2'h0
`define AKS_TGT_FUSE_RED 2'h1
`define AKS_TGT_FUSE_OBF 2'h2
`define AKS_TGT_PUF_REG 2'h3

// Fuse contents type
`define AKS_FT_RED 2'h0
`define AKS_FT_OBF 2'h1
`define AKS_FT_WRAP 2'h2

// Encryption status field of the boot header
`define AKS_SRC_NONE 3'h0
`define AKS_SRC_BATT 3'h1
`define AKS_SRC_FUSE_RED 3'h2
`define AKS_SRC_FUSE_OBF 3'h3
`define AKS_SRC_HDR_OBF 3'h4
`define AKS_SRC_FUSE_PUF 3'h5
`define AKS_SRC_EXT_PUF 3'h6
`define AKS_SRC_BOOTKEY 3'h7

// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define AKS_CRC_INIT 32'hFFFFFFFF
`define AKS_CRC_POLY 32'hEDB88320
`define AKS_KEY_WORDS 4'h8
`define AKS_HELP_WORDS 128
`define AKS_HELP_AW 7

`endif

/* File: aks_key_store.v */
// Purpose: Key store, integrity check and key-source select for the authenticated cipher.
// Assumes: One clock, synchronous reset acting as power-on reset; all side inputs on clk_i.
// Notes: Key material never reaches the bus read path.
// Operation
// R1: Accept 256-bit keys into battery or fuse store
// R2: Write-only load, no key readback path
// R3: Loader writes expected CRC32 to start check
// R4: Compute CRC32 over stored key, report pass/fail
// R5: Erase and verify battery store before load
// R6: Wrapped keys never go into battery store
// R7: Registration wraps key, keeps 4 Kb helper data
// R8: Key-encryption key is always 256 bits
// R9: Boot regenerates key-encryption key, unwraps black key
// R10: Zeroize unwrapped plaintext key after use
// R11: Off-chip wrapped key needs RSA-4096 pass first
// R12: Boot header picks source, locked until reset
// R13: No device key in non-secure boot
// R14: Authentication-only bit unlocks device key later
// R15: Exactly one key loaded before engine runs
// R16: Software switches device key or update register
// R17: Encryption status field picks device key location
// R18: Fuse holds red, obfuscated or wrapped key
// R19: Family key only in boot ROM, obfuscated only
// R20: Optional operational key replaces device key
// R21: Write-only update register, eight 32-bit words
// R22: Done and pass flags held until next load
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "aks_map.vh"

module aks_key_store #(
  parameter [255:0] FAMILY_KEY = 256'h5A
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_stb_i,
  input wire wb_cyc_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire boot_hdr_valid_i,
  input wire [2:0] boot_enc_status_i,
  input wire boot_encrypt_i,
  input wire boot_auth_only_i,
  input wire boot_op_key_en_i,
  input wire boot_rom_active_i,
  input wire boot_key_load_i,
  input wire boot_done_i,
  input wire [255:0] hdr_obf_key_i,
  input wire [255:0] ext_black_key_i,
  input wire rsa_auth_ok_i,
  input wire [255:0] puf_wkey_i,
  input wire puf_wkey_valid_i,
  input wire [31:0] puf_helper_i,
  input wire puf_helper_valid_i,
  input wire [255:0] op_key_i,
  input wire op_key_valid_i,
  input wire engine_done_i,
  output reg [255:0] engine_key_o,
  output reg engine_key_valid_o,
  output reg key_src_locked_o
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function [31:0] aks_crc_word;
    input [31:0] crc;
    input [31:0] data;
    integer i;
    reg [31:0] c;
    begin
      c = crc ^ data;
      for (i = 0; i < 32; i = i + 1) begin
        c = c[0] ? ((c >> 1) ^ `AKS_CRC_POLY) : (c >> 1);
      end
      aks_crc_word = c;
    end
  endfunction

  // Wrap and unwrap share one keyed transform
  function [255:0] aks_wrap;
    input [255:0] key;
    input [255:0] wkey;
    begin
      aks_wrap = key ^ wkey;
    end
  endfunction

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ERASE = 3'h1;
  localparam [2:0] ST_VERIFY = 3'h2;
  localparam [2:0] ST_LOAD = 3'h3;
  localparam [2:0] ST_WRAP = 3'h4;
  localparam [2:0] ST_CHECK = 3'h5;

  reg [2:0] st_r;
  reg [1:0] tgt_r;
  reg black_r;
  reg [2:0] widx_r;
  reg [3:0] cnt_r;
  reg [255:0] batt_r;
  reg [255:0] fuse_r;
  reg [255:0] stage_r;
  reg fuse_prog_r;
  reg [1:0] fuse_type_r;
  reg [31:0] crc_r;
  reg [31:0] crc_exp_r;
  reg chk_done_r;
  reg chk_pass_r;
  reg erase_ok_r;
  reg refused_r;
  reg [255:0] upd_r;
  reg [7:0] upd_wr_r;
  reg [31:0] helper_mem [0:`AKS_HELP_WORDS-1];
  reg [`AKS_HELP_AW-1:0] hlp_wr_r;
  reg [`AKS_HELP_AW-1:0] hlp_rd_r;
  reg hlp_full_r;
  reg [2:0] src_r;
  reg sec_r;
  reg unlock_r;
  reg op_en_r;
  reg [255:0] bootkey_r;
  reg bootkey_v_r;
  reg use_upd_r;
  reg puf_plain_r;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_fire = wb_cyc_i & wb_stb_i & wb_ack_o;
  wire wr_fire = bus_fire & wb_we_i & (wb_sel_i == 4'hF);
  wire rd_fire = bus_fire & ~wb_we_i;
  wire busy = (st_r != ST_IDLE) && (st_r != ST_LOAD);
  wire upd_hit = (wb_adr_i >= `AKS_ADR_UPD0) && (wb_adr_i <= `AKS_ADR_UPD7) &&
                 (wb_adr_i[1:0] == 2'h0);
  wire [2:0] upd_idx = wb_adr_i[4:2];
  wire hlp_we = puf_helper_valid_i && !hlp_full_r && (tgt_r == `AKS_TGT_PUF_REG) &&
                (st_r == ST_LOAD || st_r == ST_WRAP);
  wire wr_ctrl = wr_fire && (wb_adr_i == `AKS_ADR_CTRL);
  wire wr_key = wr_fire && (wb_adr_i == `AKS_ADR_KEY);
  wire wr_crc = wr_fire && (wb_adr_i == `AKS_ADR_CRC);
  wire wr_ksel = wr_fire && (wb_adr_i == `AKS_ADR_KSEL);
  wire rd_help = rd_fire && (wb_adr_i == `AKS_ADR_HELP);
  wire [1:0] new_tgt = wb_dat_i[`AKS_CTRL_TGT_MSB:`AKS_CTRL_TGT_LSB];
  wire new_black = wb_dat_i[`AKS_CTRL_BLACK];
  // R6: refuse black battery
  wire open_bad = ((new_tgt == `AKS_TGT_BATT) && new_black) ||
                  ((new_tgt != `AKS_TGT_BATT) && fuse_prog_r);
  wire open_req = wr_ctrl && wb_dat_i[`AKS_CTRL_OPEN] && !busy;

  // ---------------------------------------------------------------
  // Device key resolution
  // ---------------------------------------------------------------
  reg [255:0] dev_key;
  reg dev_ok;
  reg dev_puf;
  always @* begin
    dev_key = 256'h0;
    dev_ok = 1'b0;
    dev_puf = 1'b0;
    // R17: status picks location
    case (src_r)
      `AKS_SRC_BATT: begin
        // Survives reset; zero is empty
        dev_key = batt_r;
        dev_ok = |batt_r;
      end
      `AKS_SRC_FUSE_RED: begin
        dev_key = fuse_r;
        dev_ok = fuse_prog_r && (fuse_type_r == `AKS_FT_RED);
      end
      `AKS_SRC_FUSE_OBF, `AKS_SRC_HDR_OBF, `AKS_SRC_BOOTKEY: begin
        dev_key = bootkey_r;
        dev_ok = bootkey_v_r;
      end
      `AKS_SRC_FUSE_PUF: begin
        // R9: unwrap regenerated
        dev_key = aks_wrap(fuse_r, puf_wkey_i);
        dev_ok = puf_wkey_valid_i && fuse_prog_r && (fuse_type_r == `AKS_FT_WRAP);
        dev_puf = 1'b1;
      end
      `AKS_SRC_EXT_PUF: begin
        // R11: RSA pass first
        dev_key = aks_wrap(ext_black_key_i, puf_wkey_i);
        dev_ok = puf_wkey_valid_i && rsa_auth_ok_i;
        dev_puf = 1'b1;
      end
      default: dev_ok = 1'b0;
    endcase
  end

  // R13: secure boot only
  wire dev_avail = key_src_locked_o && sec_r && dev_ok;
  wire sw_dev_sel = wr_ksel && boot_done_i && !wb_dat_i[0];
  wire sw_upd_sel = wr_ksel && boot_done_i && wb_dat_i[0];
  wire load_dev = (boot_key_load_i || sw_dev_sel) && dev_avail;
  wire load_upd = sw_upd_sel && (upd_wr_r == 8'hFF);

  // ---------------------------------------------------------------
  // Load, erase and check sequencer
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      tgt_r <= `AKS_TGT_BATT;
      black_r <= 1'b0;
      widx_r <= 3'h0;
      cnt_r <= 4'h0;
      fuse_r <= 256'h0;
      stage_r <= 256'h0;
      fuse_prog_r <= 1'b0;
      fuse_type_r <= `AKS_FT_RED;
      crc_r <= `AKS_CRC_INIT;
      crc_exp_r <= 32'h0;
      chk_done_r <= 1'b0;
      chk_pass_r <= 1'b0;
      erase_ok_r <= 1'b0;
      refused_r <= 1'b0;
      hlp_wr_r <= {`AKS_HELP_AW{1'b0}};
      hlp_full_r <= 1'b0;
    end else if (ce_i) begin
      if (open_req) begin
        // R22: clear on open
        chk_done_r <= 1'b0;
        chk_pass_r <= 1'b0;
        refused_r <= 1'b0;
      end
      case (st_r)
        ST_IDLE: begin
          if (open_req && !open_bad) begin
            tgt_r <= new_tgt;
            black_r <= new_black;
            widx_r <= 3'h0;
            cnt_r <= 4'h0;
            if (new_tgt == `AKS_TGT_BATT) begin
              erase_ok_r <= 1'b0;
              st_r <= ST_ERASE;
            end else begin
              st_r <= ST_LOAD;
            end
            if (new_tgt == `AKS_TGT_PUF_REG) begin
              hlp_wr_r <= {`AKS_HELP_AW{1'b0}};
              hlp_full_r <= 1'b0;
            end
          end else if (wr_crc) begin
            // R3: expected starts check
            crc_exp_r <= wb_dat_i;
            crc_r <= `AKS_CRC_INIT;
            cnt_r <= 4'h0;
            st_r <= ST_CHECK;
          end
        end
        ST_ERASE: begin
          // R5: clear old key
          batt_r[{cnt_r[2:0], 5'h00} +: 32] <= 32'h0;
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == `AKS_KEY_WORDS - 4'h1) begin
            st_r <= ST_VERIFY;
          end
        end
        ST_VERIFY: begin
          // R5: verify erase
          if (batt_r == 256'h0) begin
            erase_ok_r <= 1'b1;
            st_r <= ST_LOAD;
          end else begin
            st_r <= ST_IDLE;
          end
        end
        ST_LOAD: begin
          if (wr_key) begin
            // R1: word to store
            case (tgt_r)
              `AKS_TGT_BATT: batt_r[{widx_r, 5'h00} +: 32] <= wb_dat_i;
              `AKS_TGT_PUF_REG: begin
                if (black_r) begin
                  fuse_r[{widx_r, 5'h00} +: 32] <= fuse_r[{widx_r, 5'h00} +: 32] | wb_dat_i;
                end else begin
                  stage_r[{widx_r, 5'h00} +: 32] <= wb_dat_i;
                end
              end
              default: fuse_r[{widx_r, 5'h00} +: 32] <= fuse_r[{widx_r, 5'h00} +: 32] | wb_dat_i;
            endcase
            widx_r <= widx_r + 3'h1;
            if (widx_r == 3'h7) begin
              if ((tgt_r == `AKS_TGT_PUF_REG) && !black_r) begin
                st_r <= ST_WRAP;
              end else begin
                st_r <= ST_IDLE;
              end
              if (tgt_r != `AKS_TGT_BATT) begin
                // R18: record key kind
                fuse_prog_r <= 1'b1;
                fuse_type_r <= (tgt_r == `AKS_TGT_FUSE_RED) ? `AKS_FT_RED :
                               (tgt_r == `AKS_TGT_FUSE_OBF) ? `AKS_FT_OBF : `AKS_FT_WRAP;
              end
            end
          end
        end
        ST_WRAP: begin
          // R7: wrap after helper
          if (puf_wkey_valid_i && hlp_full_r) begin
            // R8: full 256-bit wrap key
            fuse_r <= fuse_r | aks_wrap(stage_r, puf_wkey_i);
            stage_r <= 256'h0;
            st_r <= ST_IDLE;
          end
        end
        ST_CHECK: begin
          // R4: word-wise CRC
          if (cnt_r == `AKS_KEY_WORDS) begin
            chk_done_r <= 1'b1;
            chk_pass_r <= ((~crc_r) == crc_exp_r);
            st_r <= ST_IDLE;
          end else begin
            crc_r <= aks_crc_word(crc_r, (tgt_r == `AKS_TGT_BATT) ?
                     batt_r[{cnt_r[2:0], 5'h00} +: 32] : fuse_r[{cnt_r[2:0], 5'h00} +: 32]);
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
      // Refusals
      if ((wr_ctrl && wb_dat_i[`AKS_CTRL_OPEN] && (busy || open_bad)) ||
          (wr_key && (st_r != ST_LOAD)) || (wr_crc && (st_r != ST_IDLE))) begin
        refused_r <= 1'b1;
      end
      // R7: collect helper data
      if (hlp_we) begin
        hlp_wr_r <= hlp_wr_r + `AKS_HELP_AW'h1;
        if (hlp_wr_r == {`AKS_HELP_AW{1'b1}}) begin
          hlp_full_r <= 1'b1;
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (ce_i && hlp_we) begin
      helper_mem[hlp_wr_r] <= puf_helper_i;
    end
  end

  // ---------------------------------------------------------------
  // Key update register
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      upd_r <= 256'h0;
      upd_wr_r <= 8'h00;
    end else if (ce_i && wr_fire && upd_hit) begin
      // R21: eight write-only words
      upd_r[{upd_idx, 5'h00} +: 32] <= wb_dat_i;
      upd_wr_r[upd_idx] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Boot source lock and boot key register
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      key_src_locked_o <= 1'b0;
      src_r <= `AKS_SRC_NONE;
      sec_r <= 1'b0;
      unlock_r <= 1'b0;
      op_en_r <= 1'b0;
      bootkey_r <= 256'h0;
      bootkey_v_r <= 1'b0;
    end else if (ce_i) begin
      // R12: lock until reset
      if (boot_hdr_valid_i && !key_src_locked_o) begin
        key_src_locked_o <= 1'b1;
        src_r <= boot_enc_status_i;
        // R13: secure boot only
        // R14: auth-only unlock
        sec_r <= boot_encrypt_i || boot_auth_only_i;
        unlock_r <= boot_auth_only_i;
        op_en_r <= boot_op_key_en_i;
      end
      // R19: boot ROM only
      if (boot_rom_active_i && key_src_locked_o && !bootkey_v_r) begin
        if ((src_r == `AKS_SRC_FUSE_OBF) && fuse_prog_r && (fuse_type_r == `AKS_FT_OBF)) begin
          bootkey_r <= aks_wrap(fuse_r, FAMILY_KEY);
          bootkey_v_r <= 1'b1;
        end else if (src_r == `AKS_SRC_HDR_OBF) begin
          bootkey_r <= aks_wrap(hdr_obf_key_i, FAMILY_KEY);
          bootkey_v_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Engine key
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      engine_key_o <= 256'h0;
      engine_key_valid_o <= 1'b0;
      use_upd_r <= 1'b0;
      puf_plain_r <= 1'b0;
    end else if (ce_i) begin
      if (engine_done_i && puf_plain_r) begin
        // R10: wipe after use
        engine_key_o <= 256'h0;
        engine_key_valid_o <= 1'b0;
        puf_plain_r <= 1'b0;
      end else if (op_key_valid_i && op_en_r && engine_key_valid_o && !use_upd_r) begin
        // R20: operational key
        engine_key_o <= op_key_i;
        puf_plain_r <= 1'b0;
      end else if (load_upd) begin
        // R16: update register
        // R15: one key at once
        engine_key_o <= upd_r;
        engine_key_valid_o <= 1'b1;
        use_upd_r <= 1'b1;
        puf_plain_r <= 1'b0;
      end else if (load_dev) begin
        // R16: device key
        engine_key_o <= dev_key;
        engine_key_valid_o <= 1'b1;
        use_upd_r <= 1'b0;
        puf_plain_r <= dev_puf;
      end
    end
  end

  // ---------------------------------------------------------------
  // Wishbone answer
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      hlp_rd_r <= {`AKS_HELP_AW{1'b0}};
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      if (rd_help) begin
        hlp_rd_r <= hlp_rd_r + `AKS_HELP_AW'h1;
      end else if (open_req && !open_bad && (new_tgt == `AKS_TGT_PUF_REG)) begin
        hlp_rd_r <= {`AKS_HELP_AW{1'b0}};
      end
      if (bus_req && !wb_we_i) begin
        // R2: keys read as zero
        case (wb_adr_i)
          `AKS_ADR_CTRL: wb_dat_o <= {28'h0, black_r, 1'b0, tgt_r};
          `AKS_ADR_STAT: wb_dat_o <= {15'h0, hlp_full_r, src_r, fuse_type_r, fuse_prog_r,
                                      use_upd_r, engine_key_valid_o, unlock_r, sec_r,
                                      key_src_locked_o, refused_r, busy, erase_ok_r,
                                      chk_pass_r, chk_done_r};
          `AKS_ADR_KSEL: wb_dat_o <= {31'h0, use_upd_r};
          `AKS_ADR_HELP: wb_dat_o <= helper_mem[hlp_rd_r];
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule // aks_key_store
`default_nettype wire

/* File: aks_key_store_properties.sv */
// Purpose: Port-level checks on the key store and key-source select.
// Assumes: One clock, synchronous active-high reset, classic Wishbone slave.
// Notes: Bound to the design from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
`include "aks_map.vh"

module aks_key_store_properties (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [7:0] wb_adr_i,
  input wire wb_we_i,
  input wire wb_stb_i,
  input wire wb_cyc_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire boot_hdr_valid_i,
  input wire [2:0] boot_enc_status_i,
  input wire boot_encrypt_i,
  input wire boot_auth_only_i,
  input wire engine_done_i,
  input wire [255:0] engine_key_o,
  input wire engine_key_valid_o,
  input wire key_src_locked_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // Bus and key paths
  // ---------------------------------------------------------------
  property p_ack_pulse; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
  property p_no_readback;
    wb_ack_o && !wb_we_i && (wb_adr_i == `AKS_ADR_KEY ||
      (wb_adr_i >= `AKS_ADR_UPD0 && wb_adr_i <= `AKS_ADR_UPD7)) |-> wb_dat_o == 32'h0;
  endproperty
  a_no_readback: assert property (p_no_readback) else $error("key data on read bus");
  property p_lock_hold; key_src_locked_o |=> key_src_locked_o; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("source lock dropped");
  property p_lock_cause; $rose(key_src_locked_o) |-> $past(boot_hdr_valid_i); endproperty
  a_lock_cause: assert property (p_lock_cause) else $error("lock without header");
  property p_valid_locked; $rose(engine_key_valid_o) |-> key_src_locked_o; endproperty
  a_valid_locked: assert property (p_valid_locked) else $error("key before lock");
  property p_nonsecure;
    $rose(engine_key_valid_o) |-> $past(boot_encrypt_i || boot_auth_only_i);
  endproperty
  a_nonsecure: assert property (p_nonsecure) else $error("key in non-secure boot");
  property p_zeroize;
    key_src_locked_o && engine_done_i && (boot_enc_status_i == `AKS_SRC_FUSE_PUF ||
      boot_enc_status_i == `AKS_SRC_EXT_PUF) |=> !engine_key_valid_o && engine_key_o == 256'h0;
  endproperty
  a_zeroize: assert property (p_zeroize) else $error("unwrapped key kept");
  property p_reset;
    disable iff (1'b0) $fell(rst_i) |-> !wb_ack_o && !engine_key_valid_o && !key_src_locked_o;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  c_lock: cover property ($rose(key_src_locked_o));
  c_zero: cover property (engine_done_i && engine_key_valid_o);
  c_read: cover property (wb_ack_o && !wb_we_i && wb_adr_i == `AKS_ADR_KEY);
endmodule // aks_key_store_properties
`default_nettype wire

/* File: aks_puf_model.sv */
// Purpose: Stand-in for the unclonable function: key-encryption key and helper words.
// Assumes: Same clock as the key store.
// Notes: Wrap key value arbitrary; helper line toggles when idle.
`timescale 1ns/1ps
`default_nettype none

module aks_puf_model #(
  parameter logic [255:0] WRAP_KEY = 256'hC3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic [255:0] wkey_o,
  output logic wkey_valid_o,
  output logic [31:0] helper_o,
  output logic helper_valid_o
);
  logic [8:0] cnt_r;
  assign wkey_o = WRAP_KEY;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 9'h000;
      wkey_valid_o <= 1'b0;
      helper_valid_o <= 1'b0;
      helper_o <= 32'h0;
    end else if (start_i && cnt_r < 9'h100) begin
      cnt_r <= cnt_r + 9'h001;
      wkey_valid_o <= 1'b1;
      helper_valid_o <= cnt_r[0];
      helper_o <= cnt_r[0] ? {8'hA5, 17'h0, cnt_r[7:1]} : ~helper_o;
    end else begin
      helper_valid_o <= 1'b0;
      helper_o <= ~helper_o;
    end
  end
endmodule // aks_puf_model
`default_nettype wire

/* File: aks_key_store_tb_top.sv */
// Purpose: Self-checking bench for key load, check, boot select and zeroize.
// Assumes: 125 MHz clock; battery store survives reset.
// Notes: Random keys from an LFSR seeded at 82067.
`timescale 1ns/1ps
`default_nettype none
`include "aks_map.vh"

module aks_key_store_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, hdr_v = 1'b0, enc = 1'b0, auth = 1'b0;
  logic rom = 1'b0, kload = 1'b0, bdone = 1'b0, op_v = 1'b0, edone = 1'b0, puf_go = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [2:0] enc_st = 3'h0;
  logic [31:0] wb_wdat = 32'h0, q = 32'h0, seed = 32'd82067;
  logic [255:0] hdr_key = 256'h0, op_key = 256'h0, bkey, pkey, ukey;
  wire [31:0] wb_dat_o, puf_helper;
  wire [255:0] engine_key_o, puf_wkey;
  wire wb_ack_o, engine_key_valid_o, key_src_locked_o, puf_wkey_valid, puf_helper_valid;
  integer bad_count = 0, compares = 0;

  aks_key_store aks_key_store_inst (.clk_i, .rst_i, .ce_i(1'b1), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_wdat), .wb_sel_i(4'hF), .wb_we_i(wb_we), .wb_stb_i(wb_stb), .wb_cyc_i(wb_cyc),
    .wb_dat_o, .wb_ack_o, .boot_hdr_valid_i(hdr_v), .boot_enc_status_i(enc_st),
    .boot_encrypt_i(enc), .boot_auth_only_i(auth), .boot_op_key_en_i(1'b0),
    .boot_rom_active_i(rom), .boot_key_load_i(kload), .boot_done_i(bdone),
    .hdr_obf_key_i(hdr_key), .ext_black_key_i(256'h0), .rsa_auth_ok_i(1'b1),
    .puf_wkey_i(puf_wkey), .puf_wkey_valid_i(puf_wkey_valid), .puf_helper_i(puf_helper),
    .puf_helper_valid_i(puf_helper_valid), .op_key_i(op_key), .op_key_valid_i(op_v),
    .engine_done_i(edone), .engine_key_o, .engine_key_valid_o, .key_src_locked_o);
  aks_puf_model aks_puf_model_inst (.clk_i, .rst_i, .start_i(puf_go), .wkey_o(puf_wkey),
    .wkey_valid_o(puf_wkey_valid), .helper_o(puf_helper), .helper_valid_o(puf_helper_valid));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [31:0] crc_of(input [255:0] k);
    reg [31:0] c;
    integer i;
    c = `AKS_CRC_INIT;
    for (i = 0; i < 256; i++) c = (c >> 1) ^ ((c[0] ^ k[i]) ? `AKS_CRC_POLY : 32'h0);
    crc_of = ~c;
  endfunction
  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input [255:0] got, input [255:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input [7:0] a, input [31:0] d, input w);
    integer n = 0;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    chk(wb_ack_o, 1'b1);
    if (wb_ack_o !== 1'b1) wrap_up();
    {wb_cyc, wb_stb} <= 2'b00;
  endtask
  task automatic wait_stat(input integer b, input v);
    integer n = 0;
    do begin
      wb(`AKS_ADR_STAT, 32'h0, 1'b0);
      n++;
    end while (q[b] !== v && n < 300);
    chk(q[b], v);
    if (q[b] !== v) wrap_up();
  endtask
  task automatic load_key(input [7:0] base, input [7:0] step, input [255:0] k);
    integer i;
    for (i = 0; i < 8; i++) wb(base + step * i[7:0], k[32*i +: 32], 1'b1);
  endtask
  task automatic rnd(output [255:0] k);
    integer i;
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      k[32*i +: 32] = seed;
    end
  endtask
  task automatic pulse(input integer s);
    @(posedge clk_i);
    {hdr_v, kload, edone, op_v} <= 4'h8 >> s;
    @(posedge clk_i);
    {hdr_v, kload, edone, op_v} <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic chk_eng(input [255:0] k, input v);
    repeat (2) @(posedge clk_i);
    chk(engine_key_o, k);
    chk(engine_key_valid_o, v);
  endtask
  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial forever #4 clk_i = ~clk_i;
  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    $display("mismatch at %0t: run too long", $time);
    wrap_up();
  end
  initial begin
    do_reset();
    rnd(bkey);
    rnd(hdr_key);
    rnd(op_key);
    $display("test: battery load and check");
    wb(`AKS_ADR_STAT, 32'h0, 1'b0); chk(q, 32'h0);
    wb(8'h40, 32'h0, 1'b0); chk(q, 32'h0);
    wb(`AKS_ADR_CTRL, 32'hC, 1'b1); wb(`AKS_ADR_STAT, 32'h0, 1'b0); chk(q[4], 1'b1);
    wb(`AKS_ADR_CTRL, 32'h4, 1'b1);
    wait_stat(3, 1'b0); chk(q[2], 1'b1);
    load_key(`AKS_ADR_KEY, 8'h00, bkey);
    wb(`AKS_ADR_CRC, crc_of(bkey), 1'b1);
    wait_stat(0, 1'b1); chk(q[1], 1'b1);
    wb(`AKS_ADR_CRC, crc_of(bkey) ^ 32'h1, 1'b1);
    repeat (12) @(posedge clk_i);
    wb(`AKS_ADR_STAT, 32'h0, 1'b0); chk(q[1:0], 2'b01);
    wb(`AKS_ADR_KEY, 32'h0, 1'b0); chk(q, 32'h0);
    $display("test: boot select and update register");
    {rom, enc_st, enc} <= {1'b1, `AKS_SRC_BATT, 1'b1};
    pulse(0); chk(key_src_locked_o, 1'b1);
    pulse(1); chk_eng(bkey, 1'b1);
    pulse(3); chk_eng(bkey, 1'b1);
    enc_st <= `AKS_SRC_FUSE_RED;
    pulse(0); wb(`AKS_ADR_STAT, 32'h0, 1'b0); chk(q[15:13], `AKS_SRC_BATT);
    rnd(ukey); load_key(`AKS_ADR_UPD0, 8'h04, ukey);
    wb(`AKS_ADR_KSEL, 32'h1, 1'b1); chk_eng(bkey, 1'b1);
    bdone <= 1'b1;
    wb(`AKS_ADR_KSEL, 32'h1, 1'b1); chk_eng(ukey, 1'b1);
    wb(`AKS_ADR_UPD0, 32'h0, 1'b0); chk(q, 32'h0);
    wb(`AKS_ADR_KSEL, 32'h0, 1'b1); chk_eng(bkey, 1'b1);
    $display("test: registration, regeneration, zeroize");
    {bdone, enc} <= 2'b00;
    do_reset();
    rnd(pkey);
    wb(`AKS_ADR_CTRL, 32'h7, 1'b1);
    load_key(`AKS_ADR_KEY, 8'h00, pkey);
    puf_go <= 1'b1;
    wait_stat(16, 1'b1);
    wait_stat(3, 1'b0); chk(q[12:11], `AKS_FT_WRAP);
    wb(`AKS_ADR_HELP, 32'h0, 1'b0); chk(q, 32'hA5000000);
    {enc_st, enc} <= {`AKS_SRC_FUSE_PUF, 1'b1};
    pulse(0); pulse(1); chk_eng(pkey, 1'b1);
    pulse(2); chk_eng(256'h0, 1'b0);
    $display("test: non-secure and auth-only boot");
    {puf_go, enc_st, enc} <= {1'b0, `AKS_SRC_BATT, 1'b0};
    do_reset();
    pulse(0); pulse(1); chk_eng(256'h0, 1'b0);
    auth <= 1'b1;
    do_reset();
    pulse(0); pulse(1); chk_eng(bkey, 1'b1);
    wrap_up();
  end
endmodule // aks_key_store_tb_top

bind aks_key_store aks_key_store_properties aks_key_store_properties_inst (.clk_i, .rst_i,
  .ce_i, .wb_adr_i, .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_dat_o, .wb_ack_o, .boot_hdr_valid_i,
  .boot_enc_status_i, .boot_encrypt_i, .boot_auth_only_i, .engine_done_i, .engine_key_o,
  .engine_key_valid_o, .key_src_locked_o);
`default_nettype wire
